//--- logic/scfg_defines.vh
// Notes on behaviour
// - an eight-clock serial transfer stores its byte in config_byte only.
// - a sixteen-clock serial transfer stores its word in feedback_divide_word only.
// - each divide-word load reloads both counters; they count down together.
// - config bit 7 inverts single-ended output, swaps dual outputs; cleared at reset.
// - config bit 6 set enables single-ended output, holds dual outputs high.
// - config bit 6 clear enables dual outputs, single-ended output high impedance.
// - config bit 5 enables lock indicator; clear holds it low; cleared at reset.
// - bits 4..2 pick static low, osc, /2, /4, /8 or /16 reference output.
// - reference output field resets to divide by eight.
// - bits 1 and 0 enable feedback and reference divider outputs; else low.
// - single-ended output pulses when out of lock, high impedance when locked.
// - in phase, both detector drivers turn on together for a short moment.
// - reference counter decrements on every osc input rising edge.
// - feedback counter decrements on every vco input rising edge.
// - reference divider output idles low, pulses high 4.5 osc cycles; ratio one passes osc.
`ifndef SCFG_DEFINES_VH
`define SCFG_DEFINES_VH

// ----------------------------------------
// serial transfer lengths
// ----------------------------------------
`define SCFG_CFG_BITS      5'h08
`define SCFG_DIV_BITS      5'h10
`define SCFG_BITCNT_MAX    5'h1f

// ----------------------------------------
// config byte fields and reset values
// ----------------------------------------
`define SCFG_CFG_RESET     8'h10
`define SCFG_DIV_RESET     16'h0028
`define SCFG_B_POL         7
`define SCFG_B_SEL         6
`define SCFG_B_LDE         5
`define SCFG_F_OSC_HI      4
`define SCFG_F_OSC_LO      2
`define SCFG_B_FVE         1
`define SCFG_B_FRE         0

// ----------------------------------------
// reference output codes
// ----------------------------------------
`define SCFG_OSC_OFF       3'h0
`define SCFG_OSC_DIV1      3'h1
`define SCFG_OSC_DIV2      3'h2
`define SCFG_OSC_DIV4      3'h3
`define SCFG_OSC_DIV8      3'h4

// ----------------------------------------
// divider output timing
// ----------------------------------------
`define SCFG_FR_HIGH_RISES 3'h4
`define SCFG_REF_DIV_DEF   15'h0005
`define SCFG_REF_ONE       15'h0001

`endif

//--- logic/scfg_top.v
`timescale 1ns/100ps
`include "scfg_defines.vh"

module scfg_top #(
  parameter [14:0] REF_DIVIDE = `SCFG_REF_DIV_DEF
) (
  input  wire        i_clk_sys,
  input  wire        i_reset,
  input  wire        i_ser_clk,
  input  wire        i_ser_data,
  input  wire        i_ser_enable_n,
  input  wire        i_osc_input,
  input  wire        i_vco_input,
  output reg  [7:0]  o_config_byte,
  output reg  [15:0] o_feedback_divide_word,
  output reg         o_ref_clock_out,
  output reg         o_reference_divider_out,
  output reg         o_feedback_divider_out,
  output reg         o_single_ended_detector_out,
  output reg         o_single_ended_detector_oe,
  output reg         o_detector_phi_r,
  output reg         o_detector_phi_v,
  output reg         o_lock_indicator
);

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  reg [4:0] sync1_q;
  reg [4:0] sync2_q;
  reg [4:0] prev_q;

  always @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      sync1_q <= 5'h03;
      sync2_q <= 5'h03;
      prev_q  <= 5'h03;
    end else begin
      sync1_q <= {i_vco_input, i_osc_input, i_ser_data, i_ser_clk, i_ser_enable_n};
      sync2_q <= sync1_q;
      prev_q  <= sync2_q;
    end
  end

  wire en_n_s   = sync2_q[0];
  wire sclk_s   = sync2_q[1];
  wire sdat_s   = sync2_q[2];
  wire osc_s    = sync2_q[3];
  wire vco_s    = sync2_q[4];
  wire sclk_r   = sclk_s & ~prev_q[1];
  wire en_end   = en_n_s & ~prev_q[0];
  wire osc_r    = osc_s & ~prev_q[3];
  wire osc_f    = ~osc_s & prev_q[3];
  wire vco_r    = vco_s & ~prev_q[4];

  // ----------------------------------------
  // serial port and registers
  // ----------------------------------------
  reg [15:0] shift_q;
  reg [4:0]  bitcnt_q;
  reg [7:0]  cfg_q;
  reg [15:0] div_q;
  reg        jam_q;

  // lengths other than eight or sixteen are dropped; the count saturates so long frames cannot alias
  always @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      shift_q  <= 16'h0000;
      bitcnt_q <= 5'h00;
      cfg_q    <= `SCFG_CFG_RESET;
      div_q    <= `SCFG_DIV_RESET;
      jam_q    <= 1'b0;
    end else begin
      jam_q <= 1'b0;
      if (en_n_s) begin
        bitcnt_q <= 5'h00;
      end else if (sclk_r) begin
        shift_q <= {shift_q[14:0], sdat_s};
        if (bitcnt_q != `SCFG_BITCNT_MAX) begin
          bitcnt_q <= bitcnt_q + 5'h01;
        end
      end
      if (en_end) begin
        if (bitcnt_q == `SCFG_CFG_BITS) begin
          cfg_q <= shift_q[7:0];
        end else if (bitcnt_q == `SCFG_DIV_BITS) begin
          div_q <= shift_q;
          jam_q <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------
  // reference counter and its output
  // ----------------------------------------
  reg [14:0] rcnt_q;
  reg        fr_hi_q;
  reg [2:0]  fr_rises_q;
  reg        fr_ev_q;

  wire r_term = osc_r && (rcnt_q <= `SCFG_REF_ONE);

  always @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      rcnt_q     <= `SCFG_REF_DIV_DEF;
      fr_hi_q    <= 1'b0;
      fr_rises_q <= 3'h0;
      fr_ev_q    <= 1'b0;
    end else begin
      fr_ev_q <= 1'b0;
      if (jam_q) begin
        rcnt_q  <= REF_DIVIDE;
        fr_hi_q <= 1'b0;
      end else begin
        if (r_term) begin
          rcnt_q     <= REF_DIVIDE;
          fr_ev_q    <= 1'b1;
          fr_hi_q    <= 1'b1;
          fr_rises_q <= 3'h0;
        end else if (osc_r) begin
          rcnt_q <= rcnt_q - 15'h0001;
        end
        if (fr_hi_q && !r_term) begin
          // four more rises, then the falling edge gives the half cycle
          if (osc_r && fr_rises_q != `SCFG_FR_HIGH_RISES) begin
            fr_rises_q <= fr_rises_q + 3'h1;
          end
          if (osc_f && fr_rises_q == `SCFG_FR_HIGH_RISES) begin
            fr_hi_q <= 1'b0;
          end
        end
      end
    end
  end

  // ratio one bypasses the pulse shaper entirely
  wire fr_wave = (REF_DIVIDE == `SCFG_REF_ONE) ? osc_s : fr_hi_q;

  // ----------------------------------------
  // feedback counter and its output
  // ----------------------------------------
  reg [15:0] ncnt_q;
  reg        fv_hi_q;
  reg        fv_ev_q;

  wire n_term = vco_r && (ncnt_q <= 16'h0001);

  always @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      ncnt_q  <= `SCFG_DIV_RESET;
      fv_hi_q <= 1'b0;
      fv_ev_q <= 1'b0;
    end else begin
      fv_ev_q <= 1'b0;
      if (jam_q) begin
        ncnt_q  <= div_q;
        fv_hi_q <= 1'b0;
      end else if (n_term) begin
        ncnt_q  <= div_q;
        fv_hi_q <= 1'b1;
        fv_ev_q <= 1'b1;
      end else if (vco_r) begin
        ncnt_q  <= ncnt_q - 16'h0001;
        fv_hi_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // reference clock output divider
  // ----------------------------------------
  reg [3:0] ocnt_q;

  always @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      ocnt_q <= 4'h0;
    end else if (osc_r) begin
      ocnt_q <= ocnt_q + 4'h1;
    end
  end

  reg ref_clock_out_d;
  always @* begin
    case (cfg_q[`SCFG_F_OSC_HI:`SCFG_F_OSC_LO])
      `SCFG_OSC_OFF:  ref_clock_out_d = 1'b0;
      `SCFG_OSC_DIV1: ref_clock_out_d = osc_s;
      `SCFG_OSC_DIV2: ref_clock_out_d = ocnt_q[0];
      `SCFG_OSC_DIV4: ref_clock_out_d = ocnt_q[1];
      `SCFG_OSC_DIV8: ref_clock_out_d = ocnt_q[2];
      default:        ref_clock_out_d = ocnt_q[3];
    endcase
  end

  // ----------------------------------------
  // phase/frequency detector
  // ----------------------------------------
  reg up_q;
  reg dn_q;

  // both flags are held together for one cycle before clearing, so the
  // in-phase case shows the short overlap instead of a dead zone
  always @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      up_q <= 1'b0;
      dn_q <= 1'b0;
    end else if (jam_q) begin
      up_q <= 1'b0;
      dn_q <= 1'b0;
    end else if (up_q && dn_q) begin
      up_q <= fr_ev_q;
      dn_q <= fv_ev_q;
    end else begin
      if (fr_ev_q) begin
        up_q <= 1'b1;
      end
      if (fv_ev_q) begin
        dn_q <= 1'b1;
      end
    end
  end

  wire detector_polarity_invert     = cfg_q[`SCFG_B_POL];
  wire sel_a   = cfg_q[`SCFG_B_SEL];
  wire pump_hi = detector_polarity_invert ? dn_q : up_q;
  wire pump_lo = detector_polarity_invert ? up_q : dn_q;

  reg pd_d;
  reg pd_oe_d;
  reg phi_r_d;
  reg phi_v_d;
  always @* begin
    pd_d    = pump_hi;
    pd_oe_d = sel_a & (up_q | dn_q);
    phi_r_d = 1'b1;
    phi_v_d = 1'b1;
    if (!sel_a) begin
      pd_oe_d = 1'b0;
      phi_r_d = detector_polarity_invert ? ~dn_q : ~up_q;
      phi_v_d = detector_polarity_invert ? ~up_q : ~dn_q;
    end
    if (pump_hi && pump_lo) begin
      pd_d = 1'b1;
    end
  end

  // ----------------------------------------
  // registered outputs
  // ----------------------------------------
  always @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      o_config_byte               <= `SCFG_CFG_RESET;
      o_feedback_divide_word      <= `SCFG_DIV_RESET;
      o_ref_clock_out             <= 1'b0;
      o_reference_divider_out     <= 1'b0;
      o_feedback_divider_out      <= 1'b0;
      o_single_ended_detector_out <= 1'b0;
      o_single_ended_detector_oe  <= 1'b0;
      o_detector_phi_r            <= 1'b1;
      o_detector_phi_v            <= 1'b1;
      o_lock_indicator            <= 1'b0;
    end else begin
      o_config_byte               <= cfg_q;
      o_feedback_divide_word      <= div_q;
      o_ref_clock_out             <= ref_clock_out_d;
      o_reference_divider_out     <= cfg_q[`SCFG_B_FRE] & fr_wave;
      o_feedback_divider_out      <= cfg_q[`SCFG_B_FVE] & fv_hi_q;
      o_single_ended_detector_out <= pd_d;
      o_single_ended_detector_oe  <= pd_oe_d;
      o_detector_phi_r            <= phi_r_d;
      o_detector_phi_v            <= phi_v_d;
      // lock output is high with low pulses while one side leads
      o_lock_indicator            <= cfg_q[`SCFG_B_LDE] & ~(up_q ^ dn_q);
    end
  end

endmodule

//--- bench/scfg_assert_assertions.sv
`timescale 1ns/100ps
module scfg_assert (
  input wire        i_clk_sys,
  input wire        i_reset,
  input wire        i_ser_enable_n,
  input wire [7:0]  o_config_byte,
  input wire [15:0] o_feedback_divide_word,
  input wire        o_ref_clock_out,
  input wire        o_reference_divider_out,
  input wire        o_feedback_divider_out,
  input wire        o_single_ended_detector_oe,
  input wire        o_detector_phi_r,
  input wire        o_detector_phi_v,
  input wire        o_lock_indicator
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_reset);
  // registers may only move once the frame is over
  AST_CFG_AFTER_FRAME: assert property (!$stable(o_config_byte) |-> $past(i_ser_enable_n, 2))
    else $error("config byte changed inside a frame");
  AST_DIV_AFTER_FRAME: assert property (!$stable(o_feedback_divide_word) |-> $past(i_ser_enable_n, 2))
    else $error("divide word changed inside a frame");
  AST_ONE_REG_PER_LOAD: assert property (!$stable(o_config_byte) |-> $stable(o_feedback_divide_word))
    else $error("config load disturbed divide word");
  AST_REF_STATIC: assert property (o_config_byte[4:2] == 3'h0 [*3] |-> !o_ref_clock_out)
    else $error("reference clock not static low");
  AST_FV_GATED: assert property (!o_config_byte[1] [*3] |-> !o_feedback_divider_out)
    else $error("feedback divider output not held low");
  AST_FR_GATED: assert property (!o_config_byte[0] [*3] |-> !o_reference_divider_out)
    else $error("reference divider output not held low");
  AST_LOCK_GATED: assert property (!o_config_byte[5] [*3] |-> !o_lock_indicator)
    else $error("lock indicator not held low");
  AST_DUAL_HELD: assert property (o_config_byte[6] [*3] |-> o_detector_phi_r && o_detector_phi_v)
    else $error("dual detector outputs not held high");
  AST_SINGLE_OFF: assert property (!o_config_byte[6] [*3] |-> !o_single_ended_detector_oe)
    else $error("single-ended output not high impedance");
  cover property ($rose(o_feedback_divider_out));
  cover property ($rose(o_reference_divider_out));
  cover property ($rose(o_single_ended_detector_oe));
endmodule

bind scfg_top scfg_assert chk (.i_clk_sys, .i_reset, .i_ser_enable_n, .o_config_byte,
  .o_feedback_divide_word, .o_ref_clock_out, .o_reference_divider_out,
  .o_feedback_divider_out, .o_single_ended_detector_oe, .o_detector_phi_r,
  .o_detector_phi_v, .o_lock_indicator);

//--- bench/scfg_ctrl_model.sv
`timescale 1ns/100ps
module scfg_ctrl_model (
  input  wire i_clk_sys,
  output reg  o_ser_clk,
  output reg  o_ser_data,
  output reg  o_ser_enable_n
);
  initial begin
    o_ser_clk = 1'b0;
    o_ser_data = 1'b0;
    o_ser_enable_n = 1'b1;
  end
  // each level holds four clocks so the two-flop pin sync cannot miss it
  task wt;
    repeat (4) @(posedge i_clk_sys);
  endtask
  task send(input [15:0] v, input integer n);
    integer i;
    begin
      o_ser_enable_n <= 1'b0;
      for (i = n - 1; i >= 0; i = i - 1) begin
        wt;
        o_ser_data <= v[i];
        wt;
        o_ser_clk <= 1'b1;
        wt;
        o_ser_clk <= 1'b0;
      end
      wt;
      o_ser_enable_n <= 1'b1;
      wt;
      o_ser_data <= ~o_ser_data; // released line must not keep the last bit
    end
  endtask
endmodule

//--- bench/scfg_top_tb_top.sv
`timescale 1ns/100ps
module scfg_top_tb_top;
  reg         clk, rst, osc, vco;
  reg  [2:0]  ph;
  wire        sclk, sdat, sen_n, ref_o, fr_o, fv_o, pd, pd_oe, phr, phv, lock;
  wire [7:0]  cfg;
  wire [15:0] div;
  wire [2:0]  mon = {fv_o, fr_o, ref_o};
  integer     n_fail, check_count, p, c, e, hi, lo;
  scfg_top #(.REF_DIVIDE(15'h0005)) uut (
    .i_clk_sys(clk), .i_reset(rst), .i_ser_clk(sclk), .i_ser_data(sdat),
    .i_ser_enable_n(sen_n), .i_osc_input(osc), .i_vco_input(vco),
    .o_config_byte(cfg), .o_feedback_divide_word(div), .o_ref_clock_out(ref_o),
    .o_reference_divider_out(fr_o), .o_feedback_divider_out(fv_o),
    .o_single_ended_detector_out(pd), .o_single_ended_detector_oe(pd_oe),
    .o_detector_phi_r(phr), .o_detector_phi_v(phv), .o_lock_indicator(lock));
  scfg_ctrl_model ctl (.i_clk_sys(clk), .o_ser_clk(sclk), .o_ser_data(sdat),
    .o_ser_enable_n(sen_n));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // osc and vco both run at eight clocks a period, out of phase
  always @(posedge clk) begin
    ph  <= ph + 3'h1;
    osc <= (ph == 3'h3) ? 1'b1 : (ph == 3'h7) ? 1'b0 : osc;
    vco <= (ph == 3'h1) ? 1'b1 : (ph == 3'h5) ? 1'b0 : vco;
  end
  task tick;
    begin
      @(posedge clk);
      #1;
    end
  endtask
  task chk(input [15:0] got, input [15:0] exp);
    begin
      check_count = check_count + 1;
      if (got !== exp) begin
        n_fail = n_fail + 1;
        $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  // clocks from one rise to the next, or high time only when w is set
  task meas(input integer k, input integer w, output integer n);
    integer i;
    begin
      n = 0;
      i = 0;
      while (mon[k] !== 1'b0 && i < 900) begin tick; i = i + 1; end
      while (mon[k] !== 1'b1 && i < 900) begin tick; i = i + 1; end
      while (mon[k] === 1'b1 && i < 900) begin tick; i = i + 1; n = n + 1; end
      while (w == 0 && mon[k] === 1'b0 && i < 900) begin tick; i = i + 1; n = n + 1; end
    end
  endtask
  task cfgw(input [7:0] b);
    begin
      ctl.send({8'h00, b}, 8);
      repeat (12) tick;
    end
  endtask
  task test_reset;
    begin
      chk({8'h00, cfg}, 16'h0010);
      chk(div, 16'h0028);
      chk({10'h000, pd_oe, lock, fv_o, fr_o, phr, phv}, 16'h0003);
      meas(0, 0, p);
      meas(0, 0, p);
      chk(p[15:0], 16'h0040);
      $display("test_reset done");
    end
  endtask
  task test_frames;
    begin
      ctl.send(16'h0fff, 12);
      repeat (12) tick;
      chk({8'h00, cfg}, 16'h0010);
      chk(div, 16'h0028);
      ctl.send(16'h0031, 16);
      repeat (12) tick;
      chk(div, 16'h0031);
      chk({8'h00, cfg}, 16'h0010);
      cfgw(8'h2c);
      chk({8'h00, cfg}, 16'h002c);
      chk(div, 16'h0031);
      $display("test_frames done");
    end
  endtask
  task test_ref_clock_out;
    begin
      for (c = 1; c < 8; c = c + 1) begin
        cfgw({3'h0, c[2:0], 2'h0});
        e = (c < 5) ? (8 << (c - 1)) : 128;
        meas(0, 0, p);
        meas(0, 0, p);
        chk(p[15:0], e[15:0]);
      end
      $display("test_ref_clock_out done");
    end
  endtask
  task test_dividers;
    begin
      cfgw(8'h43);
      ctl.send(16'h0028, 16);
      c = 0;
      repeat (200) begin tick; c = c + ref_o; end
      chk(c[15:0], 16'h0000);
      meas(2, 0, p);
      meas(2, 0, p);
      chk(p[15:0], 16'h0140);
      meas(1, 0, p);
      chk(p[15:0], 16'h0028);
      meas(1, 1, p);
      chk(p[15:0], 16'h0024);
      $display("test_dividers done");
    end
  endtask
  // counts driven-high, driven-low, phi_r-low and lock-low cycles over n clocks
  task scan(input integer n);
    begin
      hi = 0;
      lo = 0;
      c = 0;
      e = 0;
      repeat (n) begin
        tick;
        hi = hi + (pd_oe === 1'b1 && pd === 1'b1);
        lo = lo + (pd_oe === 1'b1 && pd === 1'b0);
        c = c + (phr === 1'b0);
        e = e + (lock === 1'b0);
      end
    end
  endtask
  // reference runs eight times faster than feedback, so the up side dominates
  task test_detector;
    begin
      cfgw(8'h43);
      scan(400);
      chk(lo[15:0], 16'h0000);
      chk({15'h0000, hi != 0}, 16'h0001);
      cfgw(8'hc3);
      scan(400);
      chk({15'h0000, lo != 0}, 16'h0001);
      cfgw(8'h23);
      scan(400);
      chk(hi[15:0] + lo[15:0], 16'h0000);
      chk({15'h0000, c != 0}, 16'h0001);
      chk({15'h0000, e != 0}, 16'h0001);
      $display("test_detector done");
    end
  endtask
  task tally_and_finish;
    begin
      $display("checks=%0d fails=%0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0)
        $display("*** PASS ***");
      else
        $display("*** FAIL ***");
      $finish;
    end
  endtask
  initial begin
    #400000;
    n_fail = n_fail + 1;
    tally_and_finish;
  end
  initial begin
    rst = 1'b1;
    osc = 1'b0;
    vco = 1'b0;
    ph = 3'h0;
    n_fail = 0;
    check_count = 0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    repeat (4) tick;
    test_reset;
    test_frames;
    test_ref_clock_out;
    test_dividers;
    test_detector;
    tally_and_finish;
  end
endmodule
